// file: design/tsp_slave.sv
// Serial slave port of a six-channel touch sensor: address match, byte
// framing, acknowledge, clock stretching and the power-up calibration wait.
// Assumes open-drain bus pins resolved outside and a 40 MHz system clock;
// the bus clock is sampled as data, never used as a clock.
//
// Notes on behaviour
// - Data line stable while clock high.
// - Edges with clock high mark START/STOP.
// - Address byte: seven bits, direction, acknowledge.
// - Address shifted most significant bit first.
// - Matching address acknowledged low in ninth cycle.
// - Data byte: eight bits plus acknowledge slot.
// - Low acknowledges; high slot means not-acknowledge.
// - Stretch clock between bytes, at most 40us.
// - Lines only pulled low or released.
// - No normal operation before calibration time.
`timescale 1ns/1ps
module tsp_slave
    import tsp_pkg::*;
#(
    parameter int CAL_CYCLES = tsp_pkg::CAL_CYC
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_scl,
    output logic o_scl_o,
    output logic o_scl_oe_n,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe_n,
    input wire logic [tsp_pkg::ADDR_W-1:0] i_addr,
    output logic [tsp_pkg::BYTE_W-1:0] o_wr_data,
    output logic o_wr_valid,
    input wire logic i_wr_ready,
    input wire logic [tsp_pkg::BYTE_W-1:0] i_rd_data,
    input wire logic i_rd_valid,
    output logic o_rd_ready,
    output logic o_busy,
    output logic o_ready,
    output logic o_host_nack
);
    import tsp_pkg::*;

    logic scl_m_r;
    logic scl_s_r;
    logic scl_d_r;
    logic sda_m_r;
    logic sda_s_r;
    logic sda_d_r;
    logic [ADDR_W-1:0] addr_m_r;
    logic [ADDR_W-1:0] addr_s_r;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    tsp_state_t state_r;
    logic [3:0] bit_cnt_r;
    logic [BYTE_W-1:0] shift_r;
    logic [CNT_W-1:0] cal_cnt_r;
    logic [CNT_W-1:0] str_cnt_r;
    logic str_done;
    logic host_ack_r;
    logic fifo_in_ready;
    logic fifo_push;
    logic got_rd;

    initial begin
        if (CAL_CYCLES < 1 || CAL_CYCLES >= (1 << CNT_W)) begin
            $error("tsp_slave: CAL_CYCLES out of counter range");
        end
    end

    // Both lines and the jumpers arrive from outside and pass two flip-flops.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            sda_d_r <= 1'b1;
            addr_m_r <= ADDR_RST;
            addr_s_r <= ADDR_RST;
        end else begin
            scl_m_r <= i_scl;
            scl_s_r <= scl_m_r;
            scl_d_r <= scl_s_r;
            sda_m_r <= i_sda;
            sda_s_r <= sda_m_r;
            sda_d_r <= sda_s_r;
            addr_m_r <= i_addr;
            addr_s_r <= addr_m_r;
        end
    end

    assign scl_rise = scl_s_r && !scl_d_r;
    assign scl_fall = !scl_s_r && scl_d_r;
    // A data edge while the clock stays high is framing, never data.
    assign start_ev = scl_s_r && scl_d_r && sda_d_r && !sda_s_r;
    assign stop_ev = scl_s_r && scl_d_r && !sda_d_r && sda_s_r;

    // The address is not acknowledged until calibration has finished.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cal_cnt_r <= '0;
            o_ready <= 1'b0;
        end else if (!o_ready) begin
            if (cal_cnt_r == CNT_W'(CAL_CYCLES - 1)) begin
                o_ready <= 1'b1;
            end else begin
                cal_cnt_r <= cal_cnt_r + 1'b1;
            end
        end
    end

    // Bus occupied from START to STOP.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_busy <= 1'b0;
        end else if (start_ev) begin
            o_busy <= 1'b1;
        end else if (stop_ev) begin
            o_busy <= 1'b0;
        end
    end

    // Stretch time is bounded so a stalled user can never hang the host.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            str_cnt_r <= '0;
        end else if (state_r == TSP_WR_PUSH || state_r == TSP_RD_LOAD) begin
            if (!str_done) begin
                str_cnt_r <= str_cnt_r + 1'b1;
            end
        end else begin
            str_cnt_r <= '0;
        end
    end
    assign str_done = (str_cnt_r == CNT_W'(STRETCH_CYC - 1));

    assign fifo_push = (state_r == TSP_WR_PUSH);
    assign got_rd = o_rd_ready && i_rd_valid;

    // Read data is requested only while the port waits for the next byte.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rd_ready <= 1'b0;
        end else begin
            o_rd_ready <= (state_r == TSP_RD_LOAD) && !got_rd && !str_done
                && !start_ev && !stop_ev;
        end
    end

    // Both pins only ever pull low; the driven value is a constant zero.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_scl_o <= 1'b0;
            o_sda_o <= 1'b0;
        end else begin
            o_scl_o <= 1'b0;
            o_sda_o <= 1'b0;
        end
    end

    // The host makes every edge; this port only ever holds the clock low.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_scl_oe_n <= 1'b1;
        end else if (start_ev || stop_ev) begin
            o_scl_oe_n <= 1'b1;
        end else if (state_r == TSP_WR_BITS && scl_fall && bit_cnt_r == BITS_PER_BYTE) begin
            o_scl_oe_n <= 1'b0;
        end else if (state_r == TSP_ADDR_ACK && scl_fall && shift_r[0]) begin
            o_scl_oe_n <= 1'b0;
        end else if (state_r == TSP_RD_ACK && scl_fall && host_ack_r) begin
            o_scl_oe_n <= 1'b0;
        end else if (state_r == TSP_WR_PUSH && (fifo_in_ready || str_done)) begin
            o_scl_oe_n <= 1'b1;
        end else if (state_r == TSP_RD_LOAD && (got_rd || str_done)) begin
            o_scl_oe_n <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_host_nack <= 1'b0;
        end else begin
            o_host_nack <= (state_r == TSP_RD_ACK) && scl_rise && sda_s_r;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            host_ack_r <= 1'b0;
        end else if (state_r == TSP_RD_ACK && scl_rise) begin
            host_ack_r <= !sda_s_r;
        end
    end

    // Main byte sequencer; data changes only after a clock fall.
    // A repeated START restarts framing, but the user stream sees no marker
    // of it, so a host relying on one may see misaligned data.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_r <= TSP_IDLE;
            bit_cnt_r <= '0;
            shift_r <= BYTE_RST;
            o_sda_oe_n <= 1'b1;
        end else if (start_ev) begin
            state_r <= TSP_ADDR;
            bit_cnt_r <= '0;
            o_sda_oe_n <= 1'b1;
        end else if (stop_ev) begin
            state_r <= TSP_IDLE;
            o_sda_oe_n <= 1'b1;
        end else begin
            case (state_r)
                TSP_ADDR: begin
                    if (scl_rise) begin
                        shift_r <= {shift_r[BYTE_W-2:0], sda_s_r};
                        bit_cnt_r <= bit_cnt_r + 1'b1;
                    end else if (scl_fall && bit_cnt_r == BITS_PER_BYTE) begin
                        // Match on the upper seven bits; bit zero is direction.
                        if (o_ready && shift_r[BYTE_W-1:1] == addr_s_r) begin
                            o_sda_oe_n <= 1'b0;
                            state_r <= TSP_ADDR_ACK;
                        end else begin
                            state_r <= TSP_IGNORE;
                        end
                    end
                end
                TSP_ADDR_ACK: begin
                    if (scl_fall) begin
                        o_sda_oe_n <= 1'b1;
                        bit_cnt_r <= '0;
                        state_r <= shift_r[0] ? TSP_RD_LOAD : TSP_WR_BITS;
                    end
                end
                TSP_WR_BITS: begin
                    if (scl_rise) begin
                        shift_r <= {shift_r[BYTE_W-2:0], sda_s_r};
                        bit_cnt_r <= bit_cnt_r + 1'b1;
                    end else if (scl_fall && bit_cnt_r == BITS_PER_BYTE) begin
                        state_r <= TSP_WR_PUSH;
                    end
                end
                TSP_WR_PUSH: begin
                    // A full buffer past the stretch limit costs a not-acknowledge.
                    if (fifo_in_ready) begin
                        o_sda_oe_n <= 1'b0;
                        state_r <= TSP_WR_ACK;
                    end else if (str_done) begin
                        state_r <= TSP_WR_ACK;
                    end
                end
                TSP_WR_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_r <= '0;
                        state_r <= o_sda_oe_n ? TSP_IGNORE : TSP_WR_BITS;
                        o_sda_oe_n <= 1'b1;
                    end
                end
                TSP_RD_LOAD: begin
                    if (got_rd || str_done) begin
                        shift_r <= got_rd ? i_rd_data : IDLE_BYTE;
                        o_sda_oe_n <= got_rd ? i_rd_data[BYTE_W-1] : 1'b1;
                        bit_cnt_r <= '0;
                        state_r <= TSP_RD_BITS;
                    end
                end
                TSP_RD_BITS: begin
                    if (scl_fall) begin
                        if (bit_cnt_r == LAST_BIT) begin
                            o_sda_oe_n <= 1'b1;
                            state_r <= TSP_RD_ACK;
                        end else begin
                            o_sda_oe_n <= shift_r[BYTE_W-2];
                            shift_r <= {shift_r[BYTE_W-2:0], 1'b1};
                            bit_cnt_r <= bit_cnt_r + 1'b1;
                        end
                    end
                end
                TSP_RD_ACK: begin
                    if (scl_fall) begin
                        state_r <= host_ack_r ? TSP_RD_LOAD : TSP_IGNORE;
                    end
                end
                default: begin
                    state_r <= state_r;
                end
            endcase
        end
    end

    tsp_buf2 #(
        .W(BYTE_W)
    ) u_wr_buf (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_data(shift_r),
        .i_valid(fifo_push),
        .o_ready(fifo_in_ready),
        .o_data(o_wr_data),
        .o_valid(o_wr_valid),
        .i_ready(i_wr_ready)
    );
endmodule : tsp_slave

// file: design/tsp_pkg.sv
// Shared constants of the touch sensor serial slave port.
// Assumes a 40 MHz system clock that samples both bus lines.
package tsp_pkg;
    localparam int CLK_MHZ = 40;
    localparam int ADDR_W = 7;
    localparam int BYTE_W = 8;
    localparam int STRETCH_MAX_NS = 40000;
    localparam int STRETCH_CYC = (STRETCH_MAX_NS * CLK_MHZ) / 1000;
    localparam int CAL_MS = 230;
    localparam int CAL_CYC = CAL_MS * CLK_MHZ * 1000;
    localparam int CNT_W = 24;
    localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;
    localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
    localparam logic [BYTE_W-1:0] IDLE_BYTE = 8'hFF;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;

    typedef enum logic [3:0] {
        TSP_IDLE,
        TSP_ADDR,
        TSP_ADDR_ACK,
        TSP_WR_BITS,
        TSP_WR_PUSH,
        TSP_WR_ACK,
        TSP_RD_LOAD,
        TSP_RD_BITS,
        TSP_RD_ACK,
        TSP_IGNORE
    } tsp_state_t;
endpackage : tsp_pkg

// file: design/tsp_buf2.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes both sides run on the same clock; outputs come from flip-flops.
`timescale 1ns/1ps
module tsp_buf2 #(
    parameter int W = 8
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [W-1:0] i_data,
    input wire logic i_valid,
    output logic o_ready,
    output logic [W-1:0] o_data,
    output logic o_valid,
    input wire logic i_ready
);
    logic [W-1:0] slot1_r;
    logic full_r;
    logic push;
    logic pop;

    initial begin
        if (W < 1) begin
            $error("tsp_buf2: width must be at least one");
        end
    end

    assign o_ready = !full_r;
    assign push = i_valid && !full_r;
    assign pop = o_valid && i_ready;

    // The head slot drives the outputs, so a stalled reader sees a stable word.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_data <= '0;
            o_valid <= 1'b0;
            slot1_r <= '0;
            full_r <= 1'b0;
        end else begin
            if (pop) begin
                o_valid <= full_r || push;
                o_data <= full_r ? slot1_r : i_data;
                full_r <= 1'b0;
            end else if (push) begin
                if (!o_valid) begin
                    o_valid <= 1'b1;
                    o_data <= i_data;
                end else begin
                    slot1_r <= i_data;
                    full_r <= 1'b1;
                end
            end
        end
    end
endmodule : tsp_buf2

// file: verification/tsp_slave_checker.sv
// Concurrent checks on the ports of the touch sensor serial slave port.
// Assumes one 40 MHz domain and the bus levels as resolved outside the block.
`timescale 1ns/1ps
module tsp_slave_checker
    import tsp_pkg::*;
#(
    parameter int CAL_CYCLES = 100
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_scl,
    input wire logic o_scl_o,
    input wire logic o_scl_oe_n,
    input wire logic i_sda,
    input wire logic o_sda_o,
    input wire logic o_sda_oe_n,
    input wire logic [tsp_pkg::BYTE_W-1:0] o_wr_data,
    input wire logic o_wr_valid,
    input wire logic i_wr_ready,
    input wire logic i_rd_valid,
    input wire logic o_rd_ready,
    input wire logic o_busy,
    input wire logic o_ready,
    input wire logic o_host_nack
);
    import tsp_pkg::*;
    // Two cycles of slack cover the edge on which the stretch is released.
    localparam int STR_LIM = STRETCH_CYC + 2;
    int str_cnt_r;
    int cal_cnt_r;
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) str_cnt_r <= 0;
        else if (o_scl_oe_n) str_cnt_r <= 0;
        else str_cnt_r <= str_cnt_r + 1;
    end
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) cal_cnt_r <= 0;
        else if (!o_ready) cal_cnt_r <= cal_cnt_r + 1;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    sequence s_start_cond;
        i_scl && !i_sda;
    endsequence
    sequence s_stop_cond;
        i_scl && i_sda;
    endsequence
    a_open_drain: assert property (!o_scl_o && !o_sda_o)
        else $error("Bus line driven high.");
    a_stretch_bound: assert property (str_cnt_r <= STR_LIM)
        else $error("Clock stretch too long.");
    a_stretch_clk_low: assert property ($fell(o_scl_oe_n) |-> !i_scl)
        else $error("Stretch began with clock high.");
    a_sda_clk_low: assert property ($changed(o_sda_oe_n) |-> !$past(i_scl))
        else $error("Data changed while clock high.");
    a_busy_start: assert property ($rose(o_busy) |-> s_start_cond)
        else $error("Busy rose without start.");
    a_busy_stop: assert property ($fell(o_busy) |-> s_stop_cond)
        else $error("Busy fell without stop.");
    a_idle_release: assert property (!o_busy |-> o_sda_oe_n && o_scl_oe_n)
        else $error("Line pulled while bus free.");
    a_cal_quiet: assert property (!o_ready |-> o_sda_oe_n)
        else $error("Answer before calibration.");
    a_cal_time: assert property ($rose(o_ready) |->
        cal_cnt_r >= CAL_CYCLES - 1 && cal_cnt_r <= CAL_CYCLES + 1)
        else $error("Ready at wrong time.");
    a_wr_hold: assert property (o_wr_valid && !i_wr_ready |=>
        o_wr_valid && $stable(o_wr_data))
        else $error("Write byte lost before taken.");
    a_rd_take: assert property (o_rd_ready && i_rd_valid |=> !o_rd_ready)
        else $error("Read ready held after take.");
    a_nack_pulse: assert property (o_host_nack |=> !o_host_nack)
        else $error("Host nack not a pulse.");
endmodule : tsp_slave_checker
bind tsp_slave tsp_slave_checker #(.CAL_CYCLES(CAL_CYCLES)) u_chk (.i_clk, .i_arst_n,
    .i_scl, .o_scl_o, .o_scl_oe_n, .i_sda, .o_sda_o, .o_sda_oe_n, .o_wr_data,
    .o_wr_valid, .i_wr_ready, .i_rd_valid, .o_rd_ready, .o_busy, .o_ready, .o_host_nack);

// file: verification/tsp_host_model.sv
// Behavioural serial bus master facing the slave port.
// Assumes open-drain lines with pull-ups resolved by the bench; 1 means released.
`timescale 1ns/1ps
module tsp_host_model (
    input wire logic i_clk,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    int n_to = 0;
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : step
    // The device may hold the clock low, so the high phase waits for the line.
    task automatic rise;
        int n;
        o_scl = 1'b1;
        step(1);
        for (n = 0; n < 2000 && i_scl !== 1'b1; n++) step(1);
        if (n == 2000) n_to++;
    endtask : rise
    // Eight system clocks per bit give a 200 ns bus clock; the low phase of four
    // cycles leaves the port its three-cycle answer delay before the rise.
    task automatic bit_x(input logic b, output logic s);
        o_scl = 1'b0;
        step(1);
        o_sda = b;
        step(3);
        rise();
        step(1);
        s = i_sda;
        step(2);
    endtask : bit_x
    // Only ever called with the bus free; a repeated start is never sent.
    task automatic start;
        o_sda = 1'b0;
        step(6);
    endtask : start
    task automatic stop;
        o_scl = 1'b0;
        step(2);
        o_sda = 1'b0;
        step(3);
        rise();
        step(4);
        o_sda = 1'b1;
        step(6);
    endtask : stop
    task automatic put(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(d[i], s);
        bit_x(1'b1, ack);
    endtask : put
    task automatic get(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, s);
            d[i] = s;
        end
        bit_x(nack, s);
    endtask : get
endmodule : tsp_host_model

// file: verification/tsp_slave_tb_top.sv
// Self-checking bench: host model on the bus, stream drivers on the user side.
// Assumes the checker is bound into the slave port by its own file.
`timescale 1ns/1ps
module tsp_slave_tb_top;
    import tsp_pkg::*;
    localparam int CAL = 400;
    logic i_clk, i_arst_n, host_scl, host_sda, scl, sda, o_scl_o, o_scl_oe_n;
    logic o_sda_o, o_sda_oe_n, o_wr_valid, i_wr_ready, i_rd_valid, o_rd_ready;
    logic o_busy, o_ready, o_host_nack, hold_wr, a;
    logic [ADDR_W-1:0] i_addr;
    logic [BYTE_W-1:0] o_wr_data, i_rd_data, b, r0, r1;
    logic [BYTE_W-1:0] exp_q[$];
    logic [BYTE_W-1:0] rd_q[$];
    int n_mismatch = 0;
    int checks_done = 0;
    int n_nack = 0;
    assign scl = host_scl & (o_scl_oe_n | o_scl_o);
    assign sda = host_sda & (o_sda_oe_n | o_sda_o);
    tsp_slave #(.CAL_CYCLES(CAL)) u_dut (.i_clk, .i_arst_n, .i_scl(scl), .o_scl_o,
        .o_scl_oe_n, .i_sda(sda), .o_sda_o, .o_sda_oe_n, .i_addr, .o_wr_data, .o_wr_valid,
        .i_wr_ready, .i_rd_data, .i_rd_valid, .o_rd_ready, .o_busy, .o_ready, .o_host_nack);
    tsp_host_model u_host (.i_clk, .i_scl(scl), .i_sda(sda), .o_scl(host_scl),
        .o_sda(host_sda));
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    // Random stalls on the write stream; held low to fill the buffer.
    always @(posedge i_clk) i_wr_ready <= #1 (hold_wr ? 1'b0 : 1'($urandom_range(1)));
    always @(posedge i_clk) begin
        if (o_rd_ready === 1'b1 && i_rd_valid === 1'b1) void'(rd_q.pop_front());
        i_rd_valid <= #1 (rd_q.size() > 0);
        if (rd_q.size() > 0) i_rd_data <= #1 rd_q[0];
    end
    always @(posedge i_clk) begin
        if (o_wr_valid === 1'b1 && i_wr_ready === 1'b1) begin
            if (exp_q.size() == 0) check("wr_extra", 8'h01, 8'h00);
            else check("wr_data", o_wr_data, exp_q.pop_front());
        end
        if (o_host_nack === 1'b1) n_nack++;
    end
    initial begin
        repeat (60000) @(posedge i_clk);
        n_mismatch++;
        give_verdict();
    end
    initial begin
        i_arst_n = 1'b0;
        void'($urandom(32'h3246));
        i_addr = ADDR_W'($urandom);
        hold_wr = 1'b0;
        repeat (6) @(posedge i_clk);
        #1 i_arst_n = 1'b1;
        u_host.step(4);
        u_host.start();
        u_host.put({i_addr, 1'b0}, a);
        check("early_ack", a, 8'h01);
        u_host.stop();
        for (int n = 0; n < 2 * CAL && o_ready !== 1'b1; n++) @(posedge i_clk);
        #1 check("ready", o_ready, 8'h01);
        u_host.start();
        u_host.put({i_addr, 1'b0}, a);
        check("addr_ack", a, 8'h00);
        check("busy", o_busy, 8'h01);
        for (int i = 0; i < 4; i++) begin
            b = 8'($urandom);
            exp_q.push_back(b);
            u_host.put(b, a);
            check("data_ack", a, 8'h00);
        end
        u_host.stop();
        check("idle", o_busy, 8'h00);
        u_host.start();
        u_host.put({i_addr ^ 7'h01, 1'b0}, a);
        check("miss_ack", a, 8'h01);
        u_host.put(8'hA5, a);
        check("miss_data", a, 8'h01);
        u_host.stop();
        for (int n = 0; n < 300 && exp_q.size() > 0; n++) @(posedge i_clk);
        #1 check("drained", 8'(exp_q.size()), 8'h00);
        hold_wr = 1'b1;
        u_host.start();
        u_host.put({i_addr, 1'b0}, a);
        for (int i = 0; i < 4; i++) begin
            b = 8'($urandom);
            if (i < 2) exp_q.push_back(b);
            u_host.put(b, a);
            check("full_ack", a, (i < 2) ? 8'h00 : 8'h01);
        end
        u_host.stop();
        hold_wr = 1'b0;
        r0 = 8'($urandom);
        r1 = 8'($urandom);
        rd_q.push_back(r0);
        rd_q.push_back(r1);
        u_host.start();
        u_host.put({i_addr, 1'b1}, a);
        check("rd_addr", a, 8'h00);
        u_host.get(1'b0, b);
        check("rd_byte0", b, r0);
        u_host.get(1'b1, b);
        check("rd_byte1", b, r1);
        u_host.stop();
        check("nack_cnt", 8'(n_nack), 8'h01);
        u_host.start();
        u_host.put({i_addr, 1'b1}, a);
        u_host.get(1'b1, b);
        check("rd_empty", b, IDLE_BYTE);
        u_host.stop();
        check("nack_cnt2", 8'(n_nack), 8'h02);
        check("wr_left", 8'(exp_q.size()), 8'h00);
        check("host_wait", 8'(u_host.n_to), 8'h00);
        give_verdict();
    end
endmodule : tsp_slave_tb_top
